// file: rtl/reconfig_pkg.sv
package reconfig_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int CODE_W = 5;
  localparam int PMA_DW = 16;
  localparam int ADDR_W = 8;
  localparam int FILE_WORDS = 8;
  localparam int FILE_AW = 3;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_READBACK = 8'h10;

  localparam int CTRL_W = 4;
  localparam int CTRL_CHAN_MODE = 0;
  localparam int CTRL_SHARED = 1;
  localparam int CTRL_LOGICAL = 2;
  localparam int CTRL_ERRCHK = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h8;

  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_OC = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // ---------------------------------------------------------------
  // Transceiver-side register selects and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] PMA_SEL_PREEMP = 2'h1;
  localparam logic [1:0] PMA_SEL_OC = 2'h2;
  localparam logic [1:0] PMA_SEL_FILE = 2'h3;
  localparam logic [1:0] ERR_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    ST_PWR = 3'b000,
    ST_OC = 3'b001,
    ST_IDLE = 3'b010,
    ST_WR = 3'b011,
    ST_RD = 3'b100,
    ST_FILE = 3'b101,
    ST_ERR = 3'b110
  } ctl_state_t;

  // Legal pre-emphasis codes; everything else is not applicable
  function automatic logic preemp_ok(input logic [CODE_W-1:0] code);
    unique case (code)
      5'h00, 5'h01, 5'h05, 5'h09, 5'h0D: preemp_ok = 1'b1;
      5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15: preemp_ok = 1'b1;
      default: preemp_ok = 1'b0;
    endcase
  endfunction : preemp_ok

endpackage : reconfig_pkg

// file: rtl/pma_access.sv
`timescale 1ns/1ns
module pma_access
  import reconfig_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Command from the controller
  input wire logic i_start,
  input wire logic i_we,
  input wire logic [CH_W-1:0] i_chan,
  input wire logic [1:0] i_sel,
  input wire logic [PMA_DW-1:0] i_wdata,
  output logic o_idle,
  output logic o_done,
  output logic [PMA_DW-1:0] o_rdata,
  // Transceiver access port
  output logic o_pma_req,
  output logic o_pma_we,
  output logic [CH_W-1:0] o_pma_chan,
  output logic [1:0] o_pma_sel,
  output logic [PMA_DW-1:0] o_pma_wdata,
  input wire logic i_pma_ack,
  input wire logic [PMA_DW-1:0] i_pma_rdata
);
  import reconfig_pkg::*;

  wire take = i_start & ~o_pma_req;
  wire fin = o_pma_req & i_pma_ack;

  assign o_idle = ~o_pma_req;

  // Request stays up with steady fields until the transceiver acks
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pma_req <= 1'b0;
      o_pma_we <= 1'b0;
      o_pma_chan <= '0;
      o_pma_sel <= 2'h0;
      o_pma_wdata <= '0;
      o_done <= 1'b0;
      o_rdata <= '0;
    end else begin
      o_done <= fin;
      if (take) begin
        o_pma_req <= 1'b1;
        o_pma_we <= i_we;
        o_pma_chan <= i_chan;
        o_pma_sel <= i_sel;
        o_pma_wdata <= i_wdata;
      end else if (fin) begin
        o_pma_req <= 1'b0;
      end
      if (fin) begin
        o_rdata <= i_pma_rdata;
      end
    end
  end

endmodule : pma_access

// file: rtl/irq_status.sv
`timescale 1ns/1ns
module irq_status
  import reconfig_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Events and software access
  input wire logic [IRQ_W-1:0] i_set,
  input wire logic i_clr_wr,
  input wire logic [IRQ_W-1:0] i_clr_bits,
  input wire logic [IRQ_W-1:0] i_mask,
  // Status and interrupt
  output logic [IRQ_W-1:0] o_stat,
  output logic o_irq
);
  import reconfig_pkg::*;

  wire [IRQ_W-1:0] clr = i_clr_wr ? i_clr_bits : '0;
  // Set wins over a write-one-to-clear in the same cycle
  wire [IRQ_W-1:0] stat_d = (o_stat & ~clr) | i_set;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_stat <= '0;
    end else begin
      o_stat <= stat_d;
    end
  end

  assign o_irq = |(o_stat & i_mask);

endmodule : irq_status

// file: rtl/analog_reconfig.sv
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ns
// Contract
// - In analog mode busy stays high for the whole of a read or write transaction.
// - In channel mode busy stays high while the channel file is written to the channel.
// - A read is honoured only in analog mode.
// - Read-back outputs are meaningful only while read-valid is high.
// - The read-valid output exists whenever a read-back port exists.
// - An unsupported operation drops busy and raises error for two cycles, when checks are on.
// - The pre-emphasis input value is written into the transmit pre-emphasis register.
// - With shared control or logical addressing the pre-emphasis input is one 5-bit field.
// - Otherwise each channel has its own 5-bit pre-emphasis field.
// - Only the listed pre-emphasis codes are legal, 00000 meaning disabled.
// - After power-up busy is low one cycle, then high during offset cancellation.
module analog_reconfig
  import reconfig_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  // Fabric control port
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [CH_W-1:0] i_lchan,
  input wire logic [NUM_CH*CODE_W-1:0] i_tx_preemp,
  output logic o_busy,
  output logic o_data_valid,
  output logic o_error,
  output logic [NUM_CH*CODE_W-1:0] o_tx_preemp_out,
  // Channel file source
  output logic [FILE_AW-1:0] o_file_addr,
  input wire logic [PMA_DW-1:0] i_file_data,
  // Transceiver access port
  output logic o_pma_req,
  output logic o_pma_we,
  output logic [CH_W-1:0] o_pma_chan,
  output logic [1:0] o_pma_sel,
  output logic [PMA_DW-1:0] o_pma_wdata,
  input wire logic i_pma_ack,
  input wire logic [PMA_DW-1:0] i_pma_rdata
);
  import reconfig_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // One field for all channels in shared or logical mode, else one each
  function automatic logic [CODE_W-1:0] pick_code(
    input logic [NUM_CH*CODE_W-1:0] vec,
    input logic [CH_W-1:0] ch,
    input logic single
  );
    pick_code = single ? vec[CODE_W-1:0] : vec[ch*CODE_W +: CODE_W];
  endfunction : pick_code

  function automatic logic all_ok(
    input logic [NUM_CH*CODE_W-1:0] vec,
    input logic single
  );
    logic ok;
    ok = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      ok = ok & preemp_ok(pick_code(vec, CH_W'(c), single));
    end
    all_ok = ok;
  endfunction : all_ok

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  ctl_state_t state_q, state_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0] mask_q;
  logic [CH_W-1:0] chan_q;
  logic [FILE_AW-1:0] word_q;
  logic wait_q;
  logic [1:0] err_cnt_q;
  logic [NUM_CH*CODE_W-1:0] preemp_q;
  logic [NUM_CH*CODE_W-1:0] rb_q;
  logic valid_q;
  logic [31:0] prdata_q;
  logic slverr_q;

  // ---------------------------------------------------------------
  // Control decode
  // ---------------------------------------------------------------
  wire chan_mode = ctrl_q[CTRL_CHAN_MODE];
  wire logical = ctrl_q[CTRL_LOGICAL];
  wire single = ctrl_q[CTRL_SHARED] | logical;
  wire errchk = ctrl_q[CTRL_ERRCHK];
  wire idle = (state_q == ST_IDLE);

  // Requests outside idle are dropped; the user is to wait for busy and error both low
  wire rd_req = idle & i_read;
  wire wr_req = idle & i_write;
  wire rd_bad = rd_req & chan_mode;
  wire wr_bad = wr_req & ~chan_mode & ~all_ok(i_tx_preemp, single);
  wire go_err = errchk & (rd_bad | wr_bad);
  wire go_rd = rd_req & ~chan_mode & ~go_err;
  wire go_wr = wr_req & ~chan_mode & ~go_err;
  wire go_file = wr_req & chan_mode;

  // In analog mode logical addressing touches one channel, otherwise all of them
  wire [CH_W-1:0] first_ch = logical ? i_lchan : '0;
  wire last_ch = logical | (chan_q == CH_W'(NUM_CH - 1));
  wire last_word = (word_q == FILE_AW'(FILE_WORDS - 1));

  // ---------------------------------------------------------------
  // Transceiver access sequencing
  // ---------------------------------------------------------------
  wire working = (state_q == ST_OC) | (state_q == ST_WR) | (state_q == ST_RD)
               | (state_q == ST_FILE);
  wire seq_idle;
  wire seq_done;
  wire [PMA_DW-1:0] seq_rdata;
  wire seq_start = working & seq_idle & ~wait_q;
  wire seq_we = (state_q != ST_RD);
  wire [1:0] seq_sel = (state_q == ST_OC) ? PMA_SEL_OC :
                       (state_q == ST_FILE) ? PMA_SEL_FILE : PMA_SEL_PREEMP;
  wire [CODE_W-1:0] cur_code = pick_code(preemp_q, chan_q, single);
  wire [PMA_DW-1:0] seq_wdata = (state_q == ST_FILE) ? i_file_data :
                                PMA_DW'(cur_code);
  wire step_last = (state_q == ST_FILE) ? last_word : last_ch;

  pma_access u_pma (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(seq_start),
    .i_we(seq_we),
    .i_chan(chan_q),
    .i_sel(seq_sel),
    .i_wdata(seq_wdata),
    .o_idle(seq_idle),
    .o_done(seq_done),
    .o_rdata(seq_rdata),
    .o_pma_req(o_pma_req),
    .o_pma_we(o_pma_we),
    .o_pma_chan(o_pma_chan),
    .o_pma_sel(o_pma_sel),
    .o_pma_wdata(o_pma_wdata),
    .i_pma_ack(i_pma_ack),
    .i_pma_rdata(i_pma_rdata)
  );

  // ---------------------------------------------------------------
  // Main state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_PWR: state_d = ST_OC;
      ST_IDLE: begin
        if (go_err) begin
          state_d = ST_ERR;
        end else if (go_rd) begin
          state_d = ST_RD;
        end else if (go_wr) begin
          state_d = ST_WR;
        end else if (go_file) begin
          state_d = ST_FILE;
        end
      end
      ST_ERR: begin
        if (err_cnt_q == 2'h1) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        if (seq_done & step_last) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  wire finish = working & seq_done & step_last;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_PWR;
      wait_q <= 1'b0;
      chan_q <= '0;
      word_q <= '0;
      err_cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      wait_q <= working & ~seq_done & (wait_q | seq_start);
      if (state_q == ST_PWR | idle) begin
        chan_q <= idle ? first_ch : '0;
        word_q <= '0;
      end else if (seq_done & ~step_last) begin
        chan_q <= chan_q + CH_W'(1);
        word_q <= word_q + FILE_AW'(1);
      end
      err_cnt_q <= go_err ? ERR_CYCLES : (err_cnt_q - {1'b0, |err_cnt_q});
    end
  end

  // Busy spans offset cancellation, transactions and file writes
  assign o_busy = working;
  // Error state forces busy low for exactly two cycles
  assign o_error = (state_q == ST_ERR);
  assign o_file_addr = word_q;

  // ---------------------------------------------------------------
  // Pre-emphasis capture and read-back
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      preemp_q <= '0;
      rb_q <= '0;
      valid_q <= 1'b0;
    end else begin
      if (go_wr | (wr_req & ~chan_mode & ~errchk)) begin
        preemp_q <= i_tx_preemp;
      end
      if ((state_q == ST_RD) & seq_done) begin
        rb_q[chan_q*CODE_W +: CODE_W] <= seq_rdata[CODE_W-1:0];
      end
      // Read-back fields are only promised while this pulse is high
      valid_q <= (state_q == ST_RD) & finish;
    end
  end

  assign o_data_valid = valid_q;
  assign o_tx_preemp_out = rb_q;

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  wire oc_end = (state_q == ST_OC) & finish;
  wire [IRQ_W-1:0] irq_set;
  wire [IRQ_W-1:0] irq_stat;
  assign irq_set[IRQ_DONE] = finish & ~(state_q == ST_OC);
  assign irq_set[IRQ_ERR] = go_err;
  assign irq_set[IRQ_OC] = oc_end;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Data is looked up in the setup cycle so the access phase needs no wait
  wire setup = i_psel & ~i_penable;
  wire wr_acc = i_psel & i_penable & i_pwrite;
  wire hit_ctrl = (i_paddr == REG_CTRL);
  wire hit_stat = (i_paddr == REG_STATUS);
  wire hit_irq = (i_paddr == REG_IRQ_STAT);
  wire hit_mask = (i_paddr == REG_IRQ_MASK);
  wire hit_rb = (i_paddr == REG_READBACK);
  wire mapped = hit_ctrl | hit_stat | hit_irq | hit_mask | hit_rb;
  wire [31:0] status_word = {28'h0, valid_q, o_error, o_busy, ~working & ~(state_q == ST_PWR)};
  wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl_q} :
                       hit_stat ? status_word :
                       hit_irq ? {29'h0, irq_stat} :
                       hit_mask ? {29'h0, mask_q} :
                       hit_rb ? {12'h0, rb_q} : 32'h0;

  irq_status u_irq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_set(irq_set),
    .i_clr_wr(wr_acc & hit_irq & ~slverr_q),
    .i_clr_bits(i_pwdata[IRQ_W-1:0]),
    .i_mask(mask_q),
    .o_stat(irq_stat),
    .o_irq(o_irq)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= IRQ_MASK_RESET;
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else begin
      if (setup) begin
        prdata_q <= i_pwrite ? 32'h0 : rd_mux;
        slverr_q <= ~mapped;
      end
      // Mode changes mid-transaction would corrupt the loop, so writes outside idle are dropped
      if (wr_acc & hit_ctrl & idle) begin
        ctrl_q <= i_pwdata[CTRL_W-1:0];
      end
      if (wr_acc & hit_mask) begin
        mask_q <= i_pwdata[IRQ_W-1:0];
      end
    end
  end

  assign o_pready = 1'b1;
  assign o_prdata = prdata_q;
  assign o_pslverr = slverr_q & i_psel & i_penable;

endmodule : analog_reconfig

// file: test/reconfig_monitor.sv
`timescale 1ns/1ns
module reconfig_monitor
  import reconfig_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_busy,
  input wire logic o_data_valid,
  input wire logic o_error,
  input wire logic o_pma_req,
  input wire logic o_pma_we,
  input wire logic [1:0] o_pma_sel,
  input wire logic [PMA_DW-1:0] o_pma_wdata,
  input wire logic i_pma_ack
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  sequence err_pair;
    (o_error && !o_busy) [*2];
  endsequence
  sequence valid_once;
    o_data_valid ##1 !o_data_valid;
  endsequence
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_busy_powerup:
    assert property ($fell(i_rst) |-> !o_busy ##1 o_busy) else $error("busy wrong after reset");
  a_error_two:
    assert property ($rose(o_error) |-> err_pair ##1 !o_error) else $error("error not 2 cycles");
  a_valid_after:
    assert property (o_data_valid |-> $past(o_busy) && !o_busy) else $error("valid misplaced");
  a_valid_pulse:
    assert property ($rose(o_data_valid) |-> valid_once) else $error("valid not one cycle");
  a_req_holds:
    assert property (o_pma_req && !i_pma_ack |=> o_pma_req && $stable(o_pma_wdata)
      && $stable(o_pma_sel)) else $error("request released early");
  a_req_drops:
    assert property (o_pma_req && i_pma_ack |=> !o_pma_req) else $error("request held");
  a_busy_covers:
    assert property (o_pma_req |-> o_busy) else $error("busy low during access");
  a_preemp_field:
    assert property (o_pma_req && o_pma_we && o_pma_sel == PMA_SEL_PREEMP
      |-> o_pma_wdata[PMA_DW-1:CODE_W] == '0) else $error("code not zero extended");
  a_apb_ready:
    assert property (i_psel && i_penable |-> o_pready && (!o_pslverr || $past(i_psel)))
      else $error("apb answer wrong");
endmodule : reconfig_monitor

bind analog_reconfig reconfig_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy),
  .o_data_valid(o_data_valid), .o_error(o_error), .o_pma_req(o_pma_req),
  .o_pma_we(o_pma_we), .o_pma_sel(o_pma_sel), .o_pma_wdata(o_pma_wdata),
  .i_pma_ack(i_pma_ack));

// file: test/pma_model.sv
`timescale 1ns/1ns
module pma_model
  import reconfig_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [CH_W-1:0] i_chan,
  input wire logic [1:0] i_sel,
  input wire logic [PMA_DW-1:0] i_wdata,
  output logic o_ack,
  output logic [PMA_DW-1:0] o_rdata,
  output int o_file_cnt
);
  logic [CODE_W-1:0] preemp_q [NUM_CH];
  logic [1:0] cnt_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      cnt_q <= 2'h0;
      o_file_cnt <= 0;
      o_rdata <= 16'hA5A5;
    end else begin
      o_ack <= 1'b0;
      // Data toggles outside the ack cycle so a stale sample never matches
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack && cnt_q >= (i_slow ? 2'h3 : 2'h0)) begin
        o_ack <= 1'b1;
        cnt_q <= 2'h0;
        o_rdata <= {11'h0, preemp_q[i_chan]};
        if (i_we && i_sel == PMA_SEL_PREEMP) preemp_q[i_chan] <= i_wdata[CODE_W-1:0];
        if (i_we && i_sel == PMA_SEL_FILE) o_file_cnt <= o_file_cnt + 1;
      end else if (i_req && !o_ack) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule : pma_model

// file: test/analog_reconfig_tb_top.sv
`timescale 1ns/1ns
module analog_reconfig_tb_top;
  import reconfig_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_read = 1'b0, i_write = 1'b0, slow = 1'b0, o_irq, o_busy, o_error, o_data_valid;
  logic [ADDR_W-1:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, seed = 32'hF938F88F;
  logic [CH_W-1:0] i_lchan = '0, o_pma_chan;
  logic [NUM_CH*CODE_W-1:0] i_tx_preemp = '0, o_tx_preemp_out, v, e;
  logic [FILE_AW-1:0] o_file_addr;
  logic [PMA_DW-1:0] o_pma_wdata, i_pma_rdata;
  logic [1:0] o_pma_sel;
  logic o_pready, o_pslverr, o_pma_req, o_pma_we, i_pma_ack;
  logic [4:0] codes [11] = '{5'h00, 5'h01, 5'h05, 5'h09, 5'h0D, 5'h10, 5'h11, 5'h12,
    5'h13, 5'h14, 5'h15};
  logic [32:0] rd_q [$];
  logic [32:0] dv_q [$];
  logic [FILE_AW-1:0] fw = '0;
  int n_mismatch = 0, n_compared = 0, n_err = 0, k, f;
  wire logic [PMA_DW-1:0] i_file_data = {13'h1A2, o_file_addr};
  always #10 i_clk = ~i_clk;
  analog_reconfig u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq), .i_read(i_read),
    .i_write(i_write), .i_lchan(i_lchan), .i_tx_preemp(i_tx_preemp), .o_busy(o_busy),
    .o_data_valid(o_data_valid), .o_error(o_error), .o_tx_preemp_out(o_tx_preemp_out),
    .o_file_addr(o_file_addr), .i_file_data(i_file_data), .o_pma_req(o_pma_req),
    .o_pma_we(o_pma_we), .o_pma_chan(o_pma_chan), .o_pma_sel(o_pma_sel),
    .o_pma_wdata(o_pma_wdata), .i_pma_ack(i_pma_ack), .i_pma_rdata(i_pma_rdata));
  pma_model u_pma (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_req(o_pma_req),
    .i_we(o_pma_we), .i_chan(o_pma_chan), .i_sel(o_pma_sel), .i_wdata(o_pma_wdata),
    .o_ack(i_pma_ack), .o_rdata(i_pma_rdata), .o_file_cnt(f));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] x);
    n_compared++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic close_out;
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // Bus and fabric drivers
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // Idle edge: the next call must not drive psel again in this same step
    @(posedge i_clk);
  endtask : apb
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] x);
    rd_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic fab(input logic r, input logic [NUM_CH*CODE_W-1:0] d);
    if (r) dv_q.push_back({13'h0, e});
    i_tx_preemp <= d;
    i_read <= r;
    i_write <= !r;
    @(posedge i_clk);
    i_read <= 1'b0;
    i_write <= 1'b0;
    repeat (3) @(posedge i_clk);
    while (o_busy !== 1'b0 || o_error !== 1'b0) @(posedge i_clk);
  endtask : fab
  // ---------------------------------------------------------------
  // Result watcher
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    if (o_error === 1'b1) n_err++;
    if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
      chk("prdata", {o_pslverr, o_prdata}, rd_q.size() ? rd_q.pop_front() : 'x);
    if (o_data_valid !== 1'b0)
      chk("readback", o_tx_preemp_out, dv_q.size() ? dv_q.pop_front() : 'x);
    // File words must reach the channel in order 0 to 7
    if (o_pma_req === 1'b1 && i_pma_ack === 1'b1 && o_pma_sel === PMA_SEL_FILE) begin
      chk("file word", o_pma_wdata, {13'h1A2, fw});
      fw <= fw + 3'h1;
    end
  end
  initial begin
    #(20 * 20000);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    while (o_busy !== 1'b0) @(posedge i_clk);
    rd(REG_CTRL, 33'h8);
    rd(REG_STATUS, 33'h1);
    rd(REG_IRQ_STAT, 33'h4);
    rd(8'h40, 33'h1_0000_0000);
    apb(1'b1, 8'h44, rnd());
    // Twelve slots walk every legal code, per channel, prompt then slow partner
    for (int r = 0; r < 3; r++) begin
      slow <= r[0];
      for (int c = 0; c < NUM_CH; c++) v[5*c +: 5] = codes[(r * 4 + c) % 11];
      fab(1'b0, v);
      e = v;
      fab(1'b1, ~v);
      rd(REG_READBACK, {13'h0, e});
    end
    apb(1'b1, REG_CTRL, 32'hA);
    v = {15'h0, codes[rnd() % 11]};
    fab(1'b0, v | 20'hFFC00);
    e = {4{v[4:0]}};
    fab(1'b1, 20'h0);
    apb(1'b1, REG_CTRL, 32'hC);
    i_lchan <= rnd();
    v = {15'h0, codes[rnd() % 11]};
    fab(1'b0, v);
    e[5*i_lchan +: 5] = v[4:0];
    fab(1'b1, 20'h0);
    apb(1'b1, REG_CTRL, 32'h8);
    k = n_err;
    fab(1'b0, 20'hFFFFF);
    chk("error cycles", n_err - k, 2);
    fab(1'b1, 20'h0);
    apb(1'b1, REG_IRQ_MASK, 32'h2);
    chk("irq", o_irq, 1'b1);
    apb(1'b1, REG_IRQ_STAT, 32'h7);
    @(posedge i_clk);
    chk("irq", o_irq, 1'b0);
    apb(1'b1, REG_CTRL, 32'h9);
    k = f;
    fab(1'b0, 20'h0);
    chk("file words", f - k, FILE_WORDS);
    k = n_err;
    fab(1'b1, 20'h0);
    chk("read in channel mode", n_err - k, 2);
    dv_q.delete();
    repeat (4) @(posedge i_clk);
    // Reset in mid-run reruns offset cancellation
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk("busy after reset", o_busy, 1'b0);
    @(posedge i_clk);
    chk("busy in offset cancel", o_busy, 1'b1);
    while (o_busy !== 1'b0) @(posedge i_clk);
    rd(REG_IRQ_STAT, 33'h4);
    close_out();
  end
endmodule : analog_reconfig_tb_top
